// ### rtl/overtravel_guard.sv
/*
 Overtravel guard: blocks motion into tripped limits, sequences the stop,
 latches the overtravel warning, registers on an AHB-Lite slave.
 Assumes limit inputs are asynchronous pins, soft limits and motor_stopped
 come from logic on clk, and hsize is always a word.
*/
// The placing of the registers and register access over AHB-Lite were decided locally.
`include "overtravel_guard_params.svh"

module overtravel_guard #(
	parameter logic [9:0] MAX_FORCE_PCT = 10'h320
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic forward_limit_input,
	input wire logic reverse_limit_input,
	input wire logic soft_limit_fwd,
	input wire logic soft_limit_rev,
	input wire logic motor_stopped,
	output logic drive_fwd,
	output logic drive_rev,
	output overtravel_guard_pkg::stop_ctrl_type stop_ctrl,
	output logic [9:0] stop_force,
	output logic overtravel_warning
);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	overtravel_guard_pkg::cfg_type cfg_pend_r;
	overtravel_guard_pkg::cfg_type cfg_act_r;
	overtravel_guard_pkg::cfg_type cfg_rst;
	overtravel_guard_pkg::stop_state_type state_r;
	overtravel_guard_pkg::stop_state_type state_nxt;
	overtravel_guard_pkg::stop_ctrl_type ctrl_nxt;
	logic fwd_meta_r, fwd_sync_r, rev_meta_r, rev_sync_r;
	logic [9:0] force_r;
	logic [9:0] force_lim;
	logic servo_on_r, ref_fwd_r, ref_rev_r, force_mode_r;
	logic dp_wr_r;
	logic [7:0] dp_addr_r;
	logic addr_ok;
	logic wr_clear, wr_restart;
	logic ot_fwd, ot_rev, ot_fwd_q_r, ot_rev_q_r;
	logic mot_fwd, mot_rev, ot_active;
	logic ev_fwd, ev_rev, warn_set;

	assign cfg_rst = '{stop_after: `OTG_AFTER_NONE, stop_method: `OTG_STOP_DB,
		rev_cfg: `OTG_REV_USE, fwd_cfg: `OTG_FWD_USE, spare: 3'h0,
		warn_en: 1'b0, dir_rev: 1'b0};

	// ----------------------------------------------------------------
	// stop action decode
	// ----------------------------------------------------------------
	// held selects the action after standstill; force control can only brake or coast
	function automatic overtravel_guard_pkg::stop_ctrl_type stop_decode(
		input overtravel_guard_pkg::cfg_type c, input logic force_mode, input logic held);
		overtravel_guard_pkg::stop_ctrl_type s;
		s = '0;
		if (c.stop_after != `OTG_AFTER_NONE && !force_mode) begin
			if (!held)
				s.decel = 1'b1;
			else if (c.stop_after == `OTG_AFTER_ZCLAMP)
				s.zero_clamp = 1'b1;
			else
				s.coast = 1'b1;
		end else if (c.stop_method == `OTG_STOP_COAST) begin
			s.coast = 1'b1;
		end else if (!held || (c.stop_method == `OTG_STOP_DB && !force_mode)) begin
			s.dyn_brake = 1'b1;
		end else begin
			s.coast = 1'b1;
		end
		return s;
	endfunction

	// ----------------------------------------------------------------
	// limit input synchronisers
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			fwd_meta_r <= 1'b1;
			fwd_sync_r <= 1'b1;
			rev_meta_r <= 1'b1;
			rev_sync_r <= 1'b1;
		end else begin
			fwd_meta_r <= forward_limit_input;
			fwd_sync_r <= fwd_meta_r;
			rev_meta_r <= reverse_limit_input;
			rev_sync_r <= rev_meta_r;
		end
	end

	// ----------------------------------------------------------------
	// AHB-Lite slave
	// ----------------------------------------------------------------
	assign addr_ok = haddr[7:0] == `OTG_ADDR_CFG || haddr[7:0] == `OTG_ADDR_FORCE ||
		haddr[7:0] == `OTG_ADDR_CMD || haddr[7:0] == `OTG_ADDR_MOTION ||
		haddr[7:0] == `OTG_ADDR_STATUS;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			dp_wr_r <= 1'b0;
			dp_addr_r <= 8'h00;
		end else if (hready) begin
			dp_wr_r <= hsel && htrans[1] && hwrite && addr_ok && haddr[31:8] == 24'h000000;
			dp_addr_r <= haddr[7:0];
		end
	end

	// zero wait states, always OKAY
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// read data sampled at the address phase; unmapped reads return zero
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			hrdata <= 32'h00000000;
		end else if (hready && hsel && htrans[1] && !hwrite) begin
			hrdata <= 32'h00000000;
			if (haddr[31:8] == 24'h000000) begin
				unique case (haddr[7:0])
					`OTG_ADDR_CFG: hrdata <= {12'h000, cfg_pend_r[20:5], 2'b00,
						cfg_pend_r[1:0]};
					`OTG_ADDR_FORCE: hrdata <= {22'h000000, force_r};
					`OTG_ADDR_MOTION: hrdata <= {28'h0000000, force_mode_r, ref_rev_r,
						ref_fwd_r, servo_on_r};
					`OTG_ADDR_STATUS: hrdata <= {23'h000000, drive_rev, drive_fwd,
						state_r == overtravel_guard_pkg::ST_HELD,
						state_r == overtravel_guard_pkg::ST_STOPPING,
						rev_sync_r, fwd_sync_r, ot_rev, ot_fwd,
						overtravel_warning};
					default: hrdata <= 32'h00000000;
				endcase
			end
		end
	end

	assign wr_clear = dp_wr_r && dp_addr_r == `OTG_ADDR_CMD && hwdata[`OTG_CMD_CLEAR_BIT];
	assign wr_restart = dp_wr_r && dp_addr_r == `OTG_ADDR_CMD && hwdata[`OTG_CMD_RESTART_BIT];

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	// direction, limit and stop fields only reach the logic at a restart
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cfg_pend_r <= cfg_rst;
			cfg_act_r <= cfg_rst;
		end else begin
			if (dp_wr_r && dp_addr_r == `OTG_ADDR_CFG)
				cfg_pend_r <= {hwdata[19:4], 3'h0, hwdata[1:0]};
			if (wr_restart) begin
				cfg_act_r <= cfg_pend_r;
			end else begin
				cfg_act_r.warn_en <= cfg_pend_r.warn_en;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			force_r <= `OTG_FORCE_RESET;
		end else if (dp_wr_r && dp_addr_r == `OTG_ADDR_FORCE) begin
			force_r <= hwdata[9:0] > `OTG_FORCE_MAX ? `OTG_FORCE_MAX : hwdata[9:0];
		end
	end

	// reference and power from the host; a pending warning never blocks these
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			servo_on_r <= 1'b0;
			ref_fwd_r <= 1'b0;
			ref_rev_r <= 1'b0;
			force_mode_r <= 1'b0;
		end else if (dp_wr_r && dp_addr_r == `OTG_ADDR_MOTION) begin
			servo_on_r <= hwdata[`OTG_MOT_POWER_BIT];
			ref_fwd_r <= hwdata[`OTG_MOT_FWD_BIT];
			ref_rev_r <= hwdata[`OTG_MOT_REV_BIT];
			force_mode_r <= hwdata[`OTG_MOT_FORCE_BIT];
		end
	end

	// ----------------------------------------------------------------
	// motion blocking
	// ----------------------------------------------------------------
	assign ot_fwd = (cfg_act_r.fwd_cfg != `OTG_LIMIT_IGNORE && !fwd_sync_r) ||
		soft_limit_fwd;
	assign ot_rev = (cfg_act_r.rev_cfg != `OTG_LIMIT_IGNORE && !rev_sync_r) ||
		soft_limit_rev;
	// limits are physical, so compare them with the motor direction after reversal
	assign mot_fwd = servo_on_r && (cfg_act_r.dir_rev ? ref_rev_r && !ref_fwd_r
		: ref_fwd_r && !ref_rev_r);
	assign mot_rev = servo_on_r && (cfg_act_r.dir_rev ? ref_fwd_r && !ref_rev_r
		: ref_rev_r && !ref_fwd_r);
	assign ot_active = (mot_fwd && ot_fwd) || (mot_rev && ot_rev);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			drive_fwd <= 1'b0;
			drive_rev <= 1'b0;
		end else begin
			drive_fwd <= mot_fwd && !ot_fwd;
			drive_rev <= mot_rev && !ot_rev;
		end
	end

	// ----------------------------------------------------------------
	// stop sequencer
	// ----------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			overtravel_guard_pkg::ST_RUN:
				if (ot_active)
					state_nxt = overtravel_guard_pkg::ST_STOPPING;
			overtravel_guard_pkg::ST_STOPPING:
				if (!ot_active)
					state_nxt = overtravel_guard_pkg::ST_RUN;
				else if (motor_stopped)
					state_nxt = overtravel_guard_pkg::ST_HELD;
			overtravel_guard_pkg::ST_HELD:
				if (!ot_active)
					state_nxt = overtravel_guard_pkg::ST_RUN;
			// the fourth code of the state word is illegal
			default:
				state_nxt = overtravel_guard_pkg::ST_RUN;
		endcase
	end

	always_comb begin
		ctrl_nxt = '0;
		if (state_nxt != overtravel_guard_pkg::ST_RUN)
			ctrl_nxt = stop_decode(cfg_act_r, force_mode_r,
				state_nxt == overtravel_guard_pkg::ST_HELD);
	end

	assign force_lim = force_r > MAX_FORCE_PCT ? MAX_FORCE_PCT : force_r;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_r <= overtravel_guard_pkg::ST_RUN;
			stop_ctrl <= '0;
			stop_force <= 10'h000;
		end else begin
			state_r <= state_nxt;
			stop_ctrl <= ctrl_nxt;
			stop_force <= ctrl_nxt.decel ? force_lim : 10'h000;
		end
	end

	// ----------------------------------------------------------------
	// overtravel warning
	// ----------------------------------------------------------------
	// only fresh trips count: a level already present at power-on or after
	// a clear gives no edge
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ot_fwd_q_r <= 1'b0;
			ot_rev_q_r <= 1'b0;
		end else begin
			ot_fwd_q_r <= ot_fwd;
			ot_rev_q_r <= ot_rev;
		end
	end

	assign ev_fwd = ot_fwd && !ot_fwd_q_r && !mot_rev;
	assign ev_rev = ot_rev && !ot_rev_q_r && !mot_fwd;
	assign warn_set = cfg_act_r.warn_en && servo_on_r &&
		(ev_fwd || ev_rev);

	// set wins over a simultaneous clear
	always_ff @(posedge clk) begin
		if (sys_rst)
			overtravel_warning <= 1'b0;
		else
			overtravel_warning <= warn_set ||
				(overtravel_warning && !wr_clear);
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_fwd_blocked: assert property (ot_fwd |=> !drive_fwd)
		else $error("forward drive while forward overtravel");
	a_rev_blocked: assert property (ot_rev |=> !drive_rev)
		else $error("reverse drive while reverse overtravel");
	a_away_allowed: assert property (mot_rev && ot_fwd && !ot_rev |=> drive_rev)
		else $error("motion away from limit refused");
	a_dir_reversed: assert property (cfg_act_r.dir_rev && servo_on_r && ref_fwd_r &&
		!ref_rev_r && !ot_rev |=> drive_rev && !drive_fwd)
		else $error("reversal not applied");
	a_force_no_decel: assert property (force_mode_r |=> !stop_ctrl.decel)
		else $error("decel under force control");
	a_decel_force: assert property (ctrl_nxt.decel |=> stop_force == $past(force_lim) &&
		stop_force <= `OTG_FORCE_MAX)
		else $error("stop force wrong during decel");
	a_warn_raised: assert property (warn_set |=> overtravel_warning [*1] ##1
		(overtravel_warning || $past(wr_clear)))
		else $error("warning not latched");
	a_warn_off_power: assert property (!servo_on_r && !overtravel_warning
		|=> !overtravel_warning)
		else $error("warning raised with power off");
	a_warn_clear: assert property (wr_clear && !warn_set |=> !overtravel_warning)
		else $error("clear ignored");
	a_warn_option: assert property (!cfg_act_r.warn_en && !overtravel_warning
		|=> !overtravel_warning)
		else $error("warning raised while disabled");

endmodule

// ### inc/overtravel_guard_params.svh
/*
 Constants of the overtravel guard: register byte offsets, field positions,
 reset values and limits. Assumes a 32-bit AHB-Lite register bus.
*/
`ifndef OVERTRAVEL_GUARD_PARAMS_SVH
`define OVERTRAVEL_GUARD_PARAMS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OTG_ADDR_CFG 8'h00
`define OTG_ADDR_FORCE 8'h04
`define OTG_ADDR_CMD 8'h08
`define OTG_ADDR_MOTION 8'h0c
`define OTG_ADDR_STATUS 8'h10

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define OTG_CMD_CLEAR_BIT 0
`define OTG_CMD_RESTART_BIT 1
`define OTG_MOT_POWER_BIT 0
`define OTG_MOT_FWD_BIT 1
`define OTG_MOT_REV_BIT 2
`define OTG_MOT_FORCE_BIT 3

// ----------------------------------------------------------------
// codes and reset values
// ----------------------------------------------------------------
`define OTG_FWD_USE 4'h1
`define OTG_REV_USE 4'h2
`define OTG_LIMIT_IGNORE 4'h8
`define OTG_STOP_DB 4'h0
`define OTG_STOP_DB_COAST 4'h1
`define OTG_STOP_COAST 4'h2
`define OTG_AFTER_NONE 4'h0
`define OTG_AFTER_ZCLAMP 4'h1
`define OTG_AFTER_COAST 4'h2
`define OTG_FORCE_RESET 10'h320
`define OTG_FORCE_MAX 10'h320

`endif

// ### inc/overtravel_guard_pkg.sv
/*
 Types of the overtravel guard. Assumes the params header for the values.
*/
package overtravel_guard_pkg;

	// software configuration; every field except warn_en acts only after restart
	typedef struct packed {
		logic [3:0] stop_after;
		logic [3:0] stop_method;
		logic [3:0] rev_cfg;
		logic [3:0] fwd_cfg;
		logic [2:0] spare;
		logic warn_en;
		logic dir_rev;
	} cfg_type;

	// motor stop actions driven to the power stage
	typedef struct packed {
		logic dyn_brake;
		logic coast;
		logic decel;
		logic zero_clamp;
	} stop_ctrl_type;

	typedef enum logic [1:0] {
		ST_RUN,
		ST_STOPPING,
		ST_HELD
	} stop_state_type;

endpackage

// ### tb/limit_switch_model.sv
/*
 Far side of the overtravel guard: the two limit switches and the motor
 standstill feedback. Assumes stop_ctrl comes from the guard on clk.
*/
module limit_switch_model #(
	parameter int STOP_CYCLES = 4
) (
	input wire logic clk,
	input wire logic fwd_trip,
	input wire logic rev_trip,
	input wire overtravel_guard_pkg::stop_ctrl_type stop_ctrl,
	output logic forward_limit_input,
	output logic reverse_limit_input,
	output logic motor_stopped
);
	int cnt = 0;

	// ----------------------------------------------------------------
	// switches and axis
	// ----------------------------------------------------------------
	// a tripped switch opens, so a low level means overtravel
	assign forward_limit_input = !fwd_trip;
	assign reverse_limit_input = !rev_trip;
	// the axis needs a few cycles to come to rest once any stop action begins
	always_ff @(posedge clk) begin
		if (stop_ctrl == 4'h0)
			cnt <= 0;
		else if (cnt < STOP_CYCLES)
			cnt <= cnt + 1;
	end
	assign motor_stopped = (cnt == STOP_CYCLES);
endmodule

// ### tb/testbench.sv
/*
 Self-checking bench for the overtravel guard over AHB-Lite.
 Assumes one 25 MHz clock and the limit switch model on the far side.
*/
`include "overtravel_guard_params.svh"
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
	logic [1:0] htrans = 2'h0;
	logic fwd_trip = 1'b0, rev_trip = 1'b0, soft_fwd = 1'b0, soft_rev = 1'b0;
	logic fwd_pin, rev_pin, stopped, drive_fwd, drive_rev, overtravel_warning;
	logic [9:0] stop_force;
	overtravel_guard_pkg::stop_ctrl_type stop_ctrl;
	int fail_count = 0, n_compared = 0, i;
	logic [31:0] cfgs [9] = '{32'h210, 32'h1210, 32'h2210, 32'h10210, 32'h20210,
		32'h10210, 32'h280, 32'h810, 32'h211};
	logic [3:0] mots [9] = '{4'h3, 4'h3, 4'h3, 4'h3, 4'h3, 4'hb, 4'h3, 4'h5, 4'h3};
	logic [1:0] trips [9] = '{2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h1, 2'h1};
	logic [3:0] e1 [9] = '{4'h8, 4'h8, 4'h4, 4'h2, 4'h2, 4'h8, 4'h0, 4'h0, 4'h8};
	logic [3:0] e2 [9] = '{4'h8, 4'h4, 4'h4, 4'h1, 4'h4, 4'h4, 4'h0, 4'h0, 4'h8};

	initial begin
		forever #20 clk = ~clk;
	end

	overtravel_guard DUT (.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.forward_limit_input(fwd_pin), .reverse_limit_input(rev_pin),
		.soft_limit_fwd(soft_fwd), .soft_limit_rev(soft_rev), .motor_stopped(stopped),
		.drive_fwd(drive_fwd), .drive_rev(drive_rev), .stop_ctrl(stop_ctrl),
		.stop_force(stop_force), .overtravel_warning(overtravel_warning));

	limit_switch_model far_side (.clk(clk), .fwd_trip(fwd_trip), .rev_trip(rev_trip),
		.stop_ctrl(stop_ctrl), .forward_limit_input(fwd_pin),
		.reverse_limit_input(rev_pin), .motor_stopped(stopped));

	// ----------------------------------------------------------------
	// reporting
	// ----------------------------------------------------------------
	task automatic stop_test();
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic timeout();
		fail_count++;
		$display("FAIL wait bound used up");
		stop_test();
	endtask

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	// ----------------------------------------------------------------
	// bus master
	// ----------------------------------------------------------------
	// every wait is bounded; the slave may stretch any phase
	task automatic bus_wait();
		int k;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (hreadyout !== 1'b1 && k < 50);
		if (hreadyout !== 1'b1)
			timeout();
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= 1'b1;
		htrans <= 2'h2;
		bus_wait();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		bus_wait();
	endtask

	task automatic rd(input logic [31:0] a, output logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= 1'b0;
		htrans <= 2'h2;
		bus_wait();
		hsel <= 1'b0;
		htrans <= 2'h0;
		bus_wait();
		d = hrdata;
	endtask

	// clears any old warning, then trips a limit briefly under a given motion word
	task automatic trip_case(input logic [3:0] m, input logic f, r, s, input logic e);
		wr(`OTG_ADDR_CMD, 32'h1);
		wr(`OTG_ADDR_MOTION, {28'h0, m});
		fwd_trip <= f;
		rev_trip <= r;
		soft_fwd <= s;
		cyc(3);
		fwd_trip <= 1'b0;
		rev_trip <= 1'b0;
		soft_fwd <= 1'b0;
		cyc(8);
		check("warning", {31'h0, e}, {31'h0, overtravel_warning});
	endtask

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		logic [31:0] d;
		cyc(2);
		sys_rst <= 1'b0;
		cyc(1);
		rd(`OTG_ADDR_CFG, d);
		check("cfg reset", 32'h210, d);
		rd(`OTG_ADDR_FORCE, d);
		check("force reset", 32'h320, d);
		wr(`OTG_ADDR_FORCE, 32'h3ff);
		rd(`OTG_ADDR_FORCE, d);
		check("force cap", 32'h320, d);
		check("hresp", 32'h0, {31'h0, hresp});
		check("hreadyout", 32'h1, {31'h0, hreadyout});
		wr(32'h20, 32'hffff_ffff);
		rd(32'h20, d);
		check("unmapped", 32'h0, d);
		$display("test registers done");
		wr(`OTG_ADDR_MOTION, 32'h3);
		fwd_trip <= 1'b1;
		cyc(6);
		check("drive fwd", 32'h0, {31'h0, drive_fwd});
		wr(`OTG_ADDR_MOTION, 32'h5);
		cyc(6);
		check("drive rev away", 32'h1, {31'h0, drive_rev});
		fwd_trip <= 1'b0;
		rev_trip <= 1'b1;
		cyc(6);
		check("drive rev", 32'h0, {31'h0, drive_rev});
		rev_trip <= 1'b0;
		wr(`OTG_ADDR_MOTION, 32'h0);
		cyc(8);
		$display("test blocking done");
		wr(`OTG_ADDR_FORCE, 32'h64);
		for (int k = 0; k < 9; k++) begin
			wr(`OTG_ADDR_CFG, cfgs[k]);
			wr(`OTG_ADDR_CMD, 32'h2);
			wr(`OTG_ADDR_MOTION, {28'h0, mots[k]});
			fwd_trip <= trips[k][1];
			rev_trip <= trips[k][0];
			if (e1[k] === 4'h0)
				cyc(6);
			for (i = 0; i < 30 && stop_ctrl === 4'h0 && e1[k] !== 4'h0; i++)
				@(posedge clk);
			if (i == 30)
				timeout();
			// in the line below as well
			check("stopping", {28'h0, e1[k]}, {28'h0, stop_ctrl});
			if (e1[k] === 4'h2)
				check("stop force", 32'h64, {22'h0, stop_force});
			for (i = 0; i < 30 && stopped !== 1'b1 && e1[k] !== 4'h0; i++)
				@(posedge clk);
			if (i == 30)
				timeout();
			cyc(2);
			check("after stop", {28'h0, e2[k]}, {28'h0, stop_ctrl});
			fwd_trip <= 1'b0;
			rev_trip <= 1'b0;
			wr(`OTG_ADDR_MOTION, 32'h0);
			cyc(8);
		end
		$display("test stopping done");
		wr(`OTG_ADDR_CFG, 32'h212);
		wr(`OTG_ADDR_CMD, 32'h2);
		trip_case(4'h3, 1'b1, 1'b0, 1'b0, 1'b1);
		rd(`OTG_ADDR_STATUS, d);
		check("status warning", 32'h1, {31'h0, d[0]});
		wr(`OTG_ADDR_MOTION, 32'h5);
		rd(`OTG_ADDR_MOTION, d);
		check("motion accepted", 32'h5, d);
		wr(`OTG_ADDR_CMD, 32'h1);
		cyc(2);
		check("cleared", 32'h0, {31'h0, overtravel_warning});
		trip_case(4'h3, 1'b0, 1'b1, 1'b0, 1'b0);
		trip_case(4'h1, 1'b0, 1'b1, 1'b0, 1'b1);
		trip_case(4'h1, 1'b1, 1'b0, 1'b0, 1'b1);
		trip_case(4'h0, 1'b1, 1'b0, 1'b0, 1'b0);
		trip_case(4'h1, 1'b0, 1'b0, 1'b1, 1'b1);
		wr(`OTG_ADDR_CMD, 32'h1);
		fwd_trip <= 1'b1;
		wr(`OTG_ADDR_MOTION, 32'h0);
		cyc(6);
		wr(`OTG_ADDR_MOTION, 32'h1);
		cyc(8);
		check("power on", 32'h0, {31'h0, overtravel_warning});
		fwd_trip <= 1'b0;
		cyc(6);
		fwd_trip <= 1'b1;
		cyc(8);
		wr(`OTG_ADDR_CMD, 32'h1);
		cyc(8);
		check("held trip", 32'h0, {31'h0, overtravel_warning});
		fwd_trip <= 1'b0;
		cyc(6);
		trip_case(4'h1, 1'b1, 1'b0, 1'b0, 1'b1);
		wr(`OTG_ADDR_CFG, 32'h210);
		trip_case(4'h1, 1'b1, 1'b0, 1'b0, 1'b0);
		$display("test warning done");
		stop_test();
	end
endmodule
